// file: stm_pkg.sv
// Purpose: Shared constants and types of the two-channel safe torque off monitor.
// Assumes: A 50 MHz system clock.
// Notes: Times are held in milliseconds; cycle counts are derived from the clock rate.
package stm_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned HZ_PER_KHZ = 1000;
  // Cycles in one millisecond of the timebase.
  localparam int unsigned MS_CYCLES = CLK_HZ / HZ_PER_KHZ;
  // Longest allowed delay from a channel opening to output cut.
  localparam int unsigned CUT_LIMIT_MS = 10;
  // Longest allowed indication delay for a deliberate stop.
  localparam int unsigned IND_STOP_MS = 100;
  // Longest allowed indication delay for a channel abnormality.
  localparam int unsigned IND_CHAN_MS = 280;
  // Time the external switching element may take for one transition.
  localparam int unsigned SWITCH_MS = 200;
  // Synchroniser depth and reset level of a channel (open is the safe level).
  localparam int unsigned SYNC_STAGES = 3;
  localparam logic CHAN_RESET = 1'b0;
  localparam int unsigned CHANNELS = 2;
  localparam int unsigned CH_A = 0;
  localparam int unsigned CH_B = 1;

  typedef enum logic [2:0] {
    STM_FLT_NONE,
    STM_FLT_E40,
    STM_FLT_E41,
    STM_FLT_E42,
    STM_FLT_E43
  } stm_fault_t;
endpackage

// file: stm_chan_sync.sv
// Purpose: Brings one safety channel input into the system clock domain.
// Assumes: The input is a pin level, high while the contact is closed.
// Notes: The clean level moves only when the second and third stages agree.
`timescale 1ns/1ns
module stm_chan_sync (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic chan_in,
  output logic chan_closed
);
  typedef struct packed {
    logic [stm_pkg::SYNC_STAGES-1:0] stage;
    logic level;
  } stm_sync_state_t;

  stm_sync_state_t state_ff;
  stm_sync_state_t nxt_state;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.stage = {state_ff.stage[stm_pkg::SYNC_STAGES-2:0], chan_in};
    // The first stage feeds only the second, so metastability cannot reach the filter.
    if (state_ff.stage[1] == state_ff.stage[2])
    begin
      nxt_state.level = state_ff.stage[2];
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      state_ff <= '{stage: {stm_pkg::SYNC_STAGES{stm_pkg::CHAN_RESET}}, level: stm_pkg::CHAN_RESET};
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign chan_closed = state_ff.level;
endmodule

// file: stm_monitor.sv
// Purpose: Two-channel safe torque off monitor; decides whether the drive output may run.
// Assumes: Power-on reset on reset; channel inputs high while closed; 50 MHz ref_clk.
// Notes: Only a power cycle (reset) clears a channel abnormality; a deliberate stop clears by key or auto.
// Notes on behaviour
// - With both channels closed and no code held the output may run and no fault is shown.
// - With both channels open and no channel fault held the output is cut and the deliberate stop code is shown.
// - With channel a open and b closed the output is cut and the channel a fault is shown.
// - With channel b open and a closed the output is cut and the channel b fault is shown.
// - When both channels have been judged abnormal a separate dual fault code is shown.
// - In every stop or fault mode the output is cut within ten milliseconds of the input change.
// - Channel a, channel b and dual faults are shown within 280 milliseconds of the trigger.
// - The deliberate stop code is shown within 100 milliseconds of both channels opening.
// - While any stop condition is active run commands are ignored and the output stays off.
// - A single-channel fault stays latched after the channels close and clears only on power cycle.
// - The deliberate stop clears only with both channels closed; a clear with a channel open does nothing.
// - The stop decision overrides every other path that could enable the output.
// - The deliberate stop clears by a stop/reset key press or automatically when configured.
`timescale 1ns/1ns
module stm_monitor #(
  parameter int unsigned MS_CYCLES = stm_pkg::MS_CYCLES,
  parameter int unsigned DISCREP_MS = stm_pkg::SWITCH_MS
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic safety_channel_a,
  input wire logic safety_channel_b,
  input wire logic run_request,
  input wire logic stop_reset_key,
  input wire logic auto_clear,
  output logic drive_enable,
  output stm_pkg::stm_fault_t fault_code,
  output logic sto_active
);
  localparam int unsigned MSW = $clog2(MS_CYCLES);
  localparam int unsigned DW = $clog2(DISCREP_MS + 1);
  localparam logic [MSW-1:0] MS_LAST = MSW'(MS_CYCLES - 1);
  localparam logic [DW-1:0] DISC_END = DW'(DISCREP_MS);
  // The synchroniser stages, the filtered level and the drive register lie between a pin and the output.
  localparam int unsigned CUT_CYCLES = stm_pkg::SYNC_STAGES + 2;

  generate
    // A window at or beyond the channel indication limit would report a single fault too late.
    // The tick phase can end the window up to one millisecond early; it never adds to it.
    if (MS_CYCLES < 2 || DISCREP_MS < 1 || DISCREP_MS + 1 >= stm_pkg::IND_CHAN_MS)
    begin : g_bad_params
      $error("stm_monitor: unsupported timing parameters");
    end
    // A timebase this short could not hold the pin to output path inside the cut limit.
    if (CUT_CYCLES >= stm_pkg::CUT_LIMIT_MS * MS_CYCLES)
    begin : g_bad_cut
      $error("stm_monitor: cut delay exceeds its limit");
    end
    // The stop code follows the same path, so it needs the same room inside its own limit.
    if (CUT_CYCLES >= stm_pkg::IND_STOP_MS * MS_CYCLES)
    begin : g_bad_stop
      $error("stm_monitor: stop indication exceeds its limit");
    end
  endgenerate

  typedef struct packed {
    logic [MSW-1:0] ms_cnt;
    logic [DW-1:0] disc_cnt;
    logic disc_active;
    logic disc_a_open;
    stm_pkg::stm_fault_t fault;
    logic drive_en;
  } stm_state_t;

  stm_state_t state_ff;
  stm_state_t nxt_state;
  logic [stm_pkg::CHANNELS-1:0] chan_pins;
  logic [stm_pkg::CHANNELS-1:0] chan_closed;
  logic both_closed;
  logic both_open;
  logic mismatch;
  logic ms_tick;
  logic disc_expired;
  logic disc_same;
  logic clear_req;

  assign chan_pins[stm_pkg::CH_A] = safety_channel_a;
  assign chan_pins[stm_pkg::CH_B] = safety_channel_b;

  // The run gate and the stop flag both read this, so they never disagree on a held fault.
  function automatic logic fault_free(input stm_pkg::stm_fault_t f);
    return f == stm_pkg::STM_FLT_NONE;
  endfunction

  function automatic logic opposite_open(
    input stm_pkg::stm_fault_t latched,
    input logic [stm_pkg::CHANNELS-1:0] closed
  );
    logic a_open;
    logic b_open;
    a_open = !closed[stm_pkg::CH_A];
    b_open = !closed[stm_pkg::CH_B];
    if (latched == stm_pkg::STM_FLT_E41)
    begin
      return b_open && !a_open;
    end
    return a_open && !b_open;
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < stm_pkg::CHANNELS; gi++)
    begin : g_sync
      stm_chan_sync u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .chan_in(chan_pins[gi]),
        .chan_closed(chan_closed[gi])
      );
    end
  endgenerate

  assign both_closed = &chan_closed;
  assign both_open = ~|chan_closed;
  assign mismatch = ^chan_closed;
  assign ms_tick = (state_ff.ms_cnt == MS_LAST);
  // The window only counts while the same channel stays open; a swap must be timed afresh.
  assign disc_same = state_ff.disc_active && (state_ff.disc_a_open == !chan_closed[stm_pkg::CH_A]);
  assign disc_expired = disc_same && (state_ff.disc_cnt == DISC_END);
  assign clear_req = stop_reset_key | auto_clear;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.ms_cnt = ms_tick ? '0 : state_ff.ms_cnt + MSW'(1);

    // allow the switch time before judging a mismatch
    if (!mismatch)
    begin
      nxt_state.disc_active = 1'b0;
      nxt_state.disc_cnt = '0;
    end
    else if (!disc_same)
    begin
      // A swap of the open channel restarts the window, so a mirrored mismatch is judged in full.
      nxt_state.disc_active = 1'b1;
      nxt_state.disc_cnt = '0;
      nxt_state.disc_a_open = !chan_closed[stm_pkg::CH_A];
    end
    else if (ms_tick && !disc_expired)
    begin
      nxt_state.disc_cnt = state_ff.disc_cnt + DW'(1);
    end

    unique case (state_ff.fault)
      stm_pkg::STM_FLT_NONE, stm_pkg::STM_FLT_E40:
      begin
        if (disc_expired && mismatch)
        begin
          // shown once the switch time has run out
          nxt_state.fault = chan_closed[stm_pkg::CH_A] ? stm_pkg::STM_FLT_E42 : stm_pkg::STM_FLT_E41;
        end
        else if (both_open)
        begin
          // shown on the cycle after both open
          nxt_state.fault = stm_pkg::STM_FLT_E40;
        end
        else if (state_ff.fault == stm_pkg::STM_FLT_E40 && both_closed && clear_req)
        begin
          nxt_state.fault = stm_pkg::STM_FLT_NONE;
        end
      end
      stm_pkg::STM_FLT_E41:
      begin
        // the other channel also judged abnormal
        if (disc_expired && opposite_open(state_ff.fault, chan_closed))
        begin
          nxt_state.fault = stm_pkg::STM_FLT_E43;
        end
      end
      stm_pkg::STM_FLT_E42:
      begin
        // the other channel also judged abnormal
        if (disc_expired && opposite_open(state_ff.fault, chan_closed))
        begin
          nxt_state.fault = stm_pkg::STM_FLT_E43;
        end
      end
      stm_pkg::STM_FLT_E43:
      begin
        nxt_state.fault = stm_pkg::STM_FLT_E43;
      end
      default:
      begin
        nxt_state.fault = stm_pkg::STM_FLT_E43;
      end
    endcase

    // run only with both closed and no fault
    // any open channel cuts on the next edge
    nxt_state.drive_en = run_request && both_closed && fault_free(state_ff.fault);
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      state_ff <= '{ms_cnt: '0, disc_cnt: '0, disc_active: 1'b0, disc_a_open: 1'b0,
        fault: stm_pkg::STM_FLT_NONE, drive_en: 1'b0};
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign drive_enable = state_ff.drive_en;
  assign fault_code = state_ff.fault;
  assign sto_active = !both_closed || !fault_free(state_ff.fault);
endmodule

// file: stm_monitor_sva.sv
// Purpose: Port assertions of the safe torque off monitor.
// Assumes: Parameters equal those of the bound monitor.
// Notes: Bound into every stm_monitor instance.
`timescale 1ns/1ns
module stm_monitor_sva #(
  parameter int unsigned MS_CYCLES = stm_pkg::MS_CYCLES,
  parameter int unsigned DISCREP_MS = stm_pkg::SWITCH_MS
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic safety_channel_a,
  input wire logic safety_channel_b,
  input wire logic run_request,
  input wire logic drive_enable,
  input stm_pkg::stm_fault_t fault_code,
  input wire logic sto_active
);
  // Allows a whole tick of phase and the synchroniser on top of the window.
  localparam int LIM = DISCREP_MS * MS_CYCLES + MS_CYCLES + 8;
  logic [31:0] mis_ff;
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      mis_ff <= 32'h0;
    else
      mis_ff <= (safety_channel_a != safety_channel_b) ? mis_ff + 32'h1 : 32'h0;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_run_needs_request: assert property (drive_enable |-> $past(run_request))
    else $error("drive on without run request");
  a_fault_cuts_drive: assert property (fault_code != stm_pkg::STM_FLT_NONE |=> !drive_enable)
    else $error("drive on while fault held");
  a_cut_in_time: assert property ($fell(safety_channel_a) |-> ##[1:8] !drive_enable)
    else $error("drive not cut in time");
  a_cut_b_time: assert property ($fell(safety_channel_b) |-> ##[1:8] !drive_enable)
    else $error("drive not cut in time on channel b");
  a_run_when_clear: assert property (run_request && !sto_active |=> drive_enable)
    else $error("drive off although run allowed");
  a_stop_code_time: assert property ((!safety_channel_a && !safety_channel_b) [*8] |->
    fault_code != stm_pkg::STM_FLT_NONE)
    else $error("stop code missing");
  a_mismatch_time: assert property (mis_ff == LIM |-> fault_code inside
    {stm_pkg::STM_FLT_E41, stm_pkg::STM_FLT_E42, stm_pkg::STM_FLT_E43})
    else $error("channel fault missing");
  a_single_latched: assert property (fault_code == stm_pkg::STM_FLT_E41 |=>
    fault_code inside {stm_pkg::STM_FLT_E41, stm_pkg::STM_FLT_E43})
    else $error("channel a fault lost");
  a_other_latched: assert property (fault_code == stm_pkg::STM_FLT_E42 |=>
    fault_code inside {stm_pkg::STM_FLT_E42, stm_pkg::STM_FLT_E43})
    else $error("channel b fault lost");
  a_dual_held: assert property (fault_code == stm_pkg::STM_FLT_E43 |=> fault_code == stm_pkg::STM_FLT_E43)
    else $error("dual fault lost");
  a_clear_refused: assert property (fault_code == stm_pkg::STM_FLT_E40 &&
    !(safety_channel_a && safety_channel_b) |=> fault_code != stm_pkg::STM_FLT_NONE)
    else $error("stop cleared with channel open");
  a_flag_on_fault: assert property (fault_code != stm_pkg::STM_FLT_NONE |-> sto_active)
    else $error("stop flag low with fault");
endmodule
bind stm_monitor stm_monitor_sva #(.MS_CYCLES(MS_CYCLES), .DISCREP_MS(DISCREP_MS)) i_sva (.ref_clk(ref_clk),
  .reset(reset), .safety_channel_a(safety_channel_a), .safety_channel_b(safety_channel_b),
  .run_request(run_request), .drive_enable(drive_enable), .fault_code(fault_code), .sto_active(sto_active));

// file: stm_contacts.sv
// Purpose: Model of the two external safety contacts.
// Assumes: A line is high while its contact is closed.
// Notes: SETTLE cycles stand in for contact travel; each line follows its own want through the same delay.
`timescale 1ns/1ns
module stm_contacts #(
  parameter int unsigned SETTLE = 2
) (
  input wire logic ref_clk,
  input wire logic want_a,
  input wire logic want_b,
  output logic safety_channel_a,
  output logic safety_channel_b
);
  logic [1:0] pipe_ff [SETTLE];
  always_ff @(posedge ref_clk)
  begin
    pipe_ff[0] <= {want_a, want_b};
    for (int i = 1; i < SETTLE; i++)
      pipe_ff[i] <= pipe_ff[i-1];
  end
  assign {safety_channel_a, safety_channel_b} = pipe_ff[SETTLE-1];
endmodule

// file: test_stm_monitor.sv
// Purpose: Self-checking bench of the safe torque off monitor.
// Assumes: Shortened timebase of 10 cycles a millisecond.
// Notes: Each table row starts from a fresh power-up.
`timescale 1ns/1ns
module test_stm_monitor;
  localparam int WAIT = 60;
  typedef struct {logic a; logic b; stm_pkg::stm_fault_t e; stm_pkg::stm_fault_t f; logic d;} stm_row_t;
  stm_row_t rows [4] = '{'{1'b1, 1'b1, stm_pkg::STM_FLT_NONE, stm_pkg::STM_FLT_NONE, 1'b1},
    '{1'b0, 1'b0, stm_pkg::STM_FLT_E40, stm_pkg::STM_FLT_E40, 1'b0},
    '{1'b0, 1'b1, stm_pkg::STM_FLT_NONE, stm_pkg::STM_FLT_E41, 1'b0},
    '{1'b1, 1'b0, stm_pkg::STM_FLT_NONE, stm_pkg::STM_FLT_E42, 1'b0}};
  logic ref_clk = 1'b0, reset = 1'b1, want_a = 1'b1, want_b = 1'b1;
  logic run_request = 1'b0, stop_reset_key = 1'b0, auto_clear = 1'b0;
  logic safety_channel_a, safety_channel_b, drive_enable, sto_active;
  stm_pkg::stm_fault_t fault_code;
  int mismatches = 0, n_tests = 0, cycles = 0;
  stm_contacts #(.SETTLE(2)) i_contacts (.ref_clk(ref_clk), .want_a(want_a), .want_b(want_b),
    .safety_channel_a(safety_channel_a), .safety_channel_b(safety_channel_b));
  stm_monitor #(.MS_CYCLES(10), .DISCREP_MS(3)) i_dut (.ref_clk(ref_clk), .reset(reset),
    .safety_channel_a(safety_channel_a), .safety_channel_b(safety_channel_b), .run_request(run_request),
    .stop_reset_key(stop_reset_key), .auto_clear(auto_clear), .drive_enable(drive_enable),
    .fault_code(fault_code), .sto_active(sto_active));
  initial
  begin
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic check(input string name, input logic [2:0] seen, input logic [2:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Outputs are read at the falling edge, once the launching edge has settled.
  // The task returns on a rising edge so that the next stimulus lands on a rising edge too.
  task automatic expect_out(input stm_pkg::stm_fault_t f, input logic d);
    @(negedge ref_clk);
    check("fault_code", fault_code, f);
    check("drive_enable", {2'h0, drive_enable}, {2'h0, d});
    check("sto_active", {2'h0, sto_active}, {2'h0, ~d});
    @(posedge ref_clk);
  endtask
  task automatic key();
    stop_reset_key <= 1'b1;
    tick(1);
    stop_reset_key <= 1'b0;
    tick(4);
  endtask
  task automatic power_up();
    reset <= 1'b1;
    want_a <= 1'b1;
    want_b <= 1'b1;
    run_request <= 1'b1;
    tick(8);
    reset <= 1'b0;
    tick(10);
    key();
  endtask
  task automatic final_report();
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      final_report();
    end
  end
  initial
  begin
    foreach (rows[i])
    begin
      power_up();
      expect_out(stm_pkg::STM_FLT_NONE, 1'b1);
      want_a <= rows[i].a;
      want_b <= rows[i].b;
      tick(8);
      expect_out(rows[i].e, rows[i].d);
      tick(WAIT);
      expect_out(rows[i].f, rows[i].d);
    end
    want_b <= 1'b1;
    tick(10);
    key();
    expect_out(stm_pkg::STM_FLT_E42, 1'b0);
    want_a <= 1'b0;
    tick(WAIT);
    expect_out(stm_pkg::STM_FLT_E43, 1'b0);
    power_up();
    want_a <= 1'b0;
    want_b <= 1'b0;
    tick(WAIT);
    want_a <= 1'b1;
    tick(8);
    key();
    expect_out(stm_pkg::STM_FLT_E40, 1'b0);
    want_b <= 1'b1;
    tick(8);
    key();
    expect_out(stm_pkg::STM_FLT_NONE, 1'b1);
    auto_clear <= 1'b1;
    want_a <= 1'b0;
    want_b <= 1'b0;
    tick(WAIT);
    want_a <= 1'b1;
    want_b <= 1'b1;
    tick(12);
    expect_out(stm_pkg::STM_FLT_NONE, 1'b1);
    run_request <= 1'b0;
    tick(2);
    @(negedge ref_clk);
    check("drive_enable", {2'h0, drive_enable}, 3'h0);
    check("sto_active", {2'h0, sto_active}, 3'h0);
    @(posedge ref_clk);
    run_request <= 1'b1;
    tick(2);
    expect_out(stm_pkg::STM_FLT_NONE, 1'b1);
    final_report();
  end
endmodule
